// [verilog/link_status_power.sv]
// status and power register bank of the serial output link
//
// Overview of operation
// - link up shown as read-only status bit
// - status bit mirrors live sync request level
// - sysref clock realignment sets sticky flag
// - first sysref after enable sets flag
// - pll lock shown as read-only bit
// - b power-down stops channel b and bound
// - a power-down stops channel a and bound
// - controller refuses power change while encoder enabled
// - both channels down powers whole link down
// - b off keeps link a running
// - link a extra bits enable lane clocks
// - spare serializer bit adds serializer enables
// - controller changes extra lanes with encoder off
// - extra lanes ignore mode and test selection, which pass straight to lane_mode_o and lane_pattern_o
// - channel power-down overrides extra lane enables
// - serializer n clocked only if lower lanes on
// - link b extra bits behave as link a
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module link_status_power
   import lane_ctl_pkg::*;
#(
   parameter int LANES = 8
)
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // register port
   lane_ctl_if.dev bus,
   // link events and state
   input wire logic link_up_i,
   input wire logic sync_n_i,
   input wire logic sysref_realign_i,
   input wire logic sysref_event_i,
   input wire logic pll_locked_i,
   input wire logic [3:0] link_mode_select_i,
   input wire logic [3:0] test_pattern_select_i,
   // power and lane controls
   output logic channel_a_on_o,
   output logic channel_b_on_o,
   output logic link_subsystem_on_o,
   output logic link_a_on_o,
   output logic b_samples_valid_o,
   output logic [LANES-1:0] lane_clk_en_a_o,
   output logic [LANES-1:0] lane_clk_en_b_o,
   output logic [LANES-1:0] ser_en_a_o,
   output logic [LANES-1:0] ser_en_b_o,
   output logic [3:0] lane_mode_o,
   output logic [3:0] lane_pattern_o
);
   initial
   begin
      if (LANES != 8)
         $error("lane count must be 8");
   end

   typedef struct packed {
      logic [7:0] pd;
      logic [7:0] xa;
      logic [7:0] xb;
      logic [7:0] rdata;
      logic ack;
      logic armed;
      logic [LANES-1:0] clk_a;
      logic [LANES-1:0] clk_b;
      logic [LANES-1:0] ser_a;
      logic [LANES-1:0] ser_b;
      logic on_a;
      logic on_b;
   } st_t;
   st_t s_r;
   st_t s_nxt;

   logic realigned;
   logic lmfc_set;
   logic wr_status;
   logic lmfc_first;

   assign wr_status = bus.req && bus.wr && !s_r.ack
      && bus.addr == OFS_LINK_STATUS;
   // first sysref while encoder enabled and not yet seen
   assign lmfc_first = sysref_event_i && bus.link_encoder_enable
      && s_r.armed;

   sticky_flag u_realign
   (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .set_i(sysref_realign_i),
      .clear_i(wr_status && bus.wdata[BIT_REALIGNED]),
      .flag_o(realigned)
   );
   sticky_flag u_lmfc
   (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .set_i(lmfc_first),
      .clear_i(wr_status && bus.wdata[BIT_LMFC_SET]),
      .flag_o(lmfc_set)
   );

   // lane n gets a clock only while lanes 0..n-1 also run
   function automatic logic [LANES-1:0] chain(input logic [LANES-1:0] en);
      logic [LANES-1:0] c;
      c = '0;
      c[0] = en[0];
      for (int n = 1; n < LANES; n++)
         c[n] = en[n] && c[n-1];
      return c;
   endfunction

   always_comb
   begin
      logic [7:0] stat;
      logic both_down;
      logic [LANES-1:0] need;
      logic [LANES-1:0] ea;
      logic [LANES-1:0] eb;
      stat = '0;
      both_down = 1'b0;
      need = '0;
      ea = '0;
      eb = '0;
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      stat[BIT_LINK_UP] = link_up_i;
      stat[BIT_SYNC_STATUS] = sync_n_i;
      stat[BIT_REALIGNED] = realigned;
      stat[BIT_LMFC_SET] = lmfc_set;
      stat[BIT_PLL_LOCKED] = pll_locked_i;
      if (!bus.link_encoder_enable)
         s_nxt.armed = 1'b1;
      else if (sysref_event_i)
         s_nxt.armed = 1'b0;
      if (bus.req && !s_r.ack)
      begin
         s_nxt.ack = 1'b1;
         s_nxt.rdata = '0;
         case (bus.addr)
            OFS_LINK_STATUS:
               s_nxt.rdata = stat;
            OFS_CHANNEL_POWER_DOWN:
            begin
               s_nxt.rdata = s_r.pd;
               if (bus.wr)
                  s_nxt.pd = bus.wdata;
            end
            OFS_EXTRA_LANE_A:
            begin
               s_nxt.rdata = s_r.xa;
               if (bus.wr)
                  s_nxt.xa = bus.wdata;
            end
            OFS_EXTRA_LANE_B:
            begin
               s_nxt.rdata = s_r.xb;
               if (bus.wr)
                  s_nxt.xb = bus.wdata;
            end
            default:
               s_nxt.rdata = '0;
         endcase
      end
      s_nxt.on_a = !s_r.pd[BIT_PD_A];
      s_nxt.on_b = !s_r.pd[BIT_PD_B];
      both_down = s_r.pd[BIT_PD_A] && s_r.pd[BIT_PD_B];
      // lane 0 is always part of a running link; mode needs no more here
      need = '0;
      need[0] = 1'b1;
      ea = need | {s_r.xa[7:1], 1'b0};
      eb = need | {s_r.xb[7:1], 1'b0};
      // power-down wins over extra lane enables
      if (both_down || s_r.pd[BIT_PD_A])
         ea = '0;
      if (both_down || s_r.pd[BIT_PD_B])
         eb = '0;
      s_nxt.clk_a = chain(ea);
      s_nxt.clk_b = chain(eb);
      s_nxt.ser_a = s_r.xa[BIT_SPARE_SER] ? s_nxt.clk_a
         : (s_nxt.clk_a & need);
      s_nxt.ser_b = s_r.xb[BIT_SPARE_SER] ? s_nxt.clk_b
         : (s_nxt.clk_b & need);
   end

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s_r <= '0;
         s_r.pd <= RST_REG8;
         s_r.xa <= RST_REG8;
         s_r.xb <= RST_REG8;
         s_r.armed <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   assign bus.rdata = s_r.rdata;
   assign bus.ack = s_r.ack;
   assign channel_a_on_o = s_r.on_a;
   assign channel_b_on_o = s_r.on_b;
   assign link_subsystem_on_o = s_r.on_a || s_r.on_b;
   // link a carries on when only b is off
   assign link_a_on_o = s_r.on_a;
   assign b_samples_valid_o = s_r.on_b;
   assign lane_clk_en_a_o = s_r.clk_a;
   assign lane_clk_en_b_o = s_r.clk_b;
   assign ser_en_a_o = s_r.ser_a;
   assign ser_en_b_o = s_r.ser_b;
   assign lane_mode_o = link_mode_select_i;
   assign lane_pattern_o = test_pattern_select_i;
endmodule

// [include/lane_ctl_pkg.sv]
// constants shared by the lane status and power control ends
package lane_ctl_pkg;
   // device register offsets
   localparam logic [9:0] OFS_LINK_STATUS = 10'h208;
   localparam logic [9:0] OFS_CHANNEL_POWER_DOWN = 10'h209;
   localparam logic [9:0] OFS_EXTRA_LANE_A = 10'h20A;
   localparam logic [9:0] OFS_EXTRA_LANE_B = 10'h20B;
   // link_status fields
   localparam int BIT_LINK_UP = 6;
   localparam int BIT_SYNC_STATUS = 5;
   localparam int BIT_REALIGNED = 4;
   localparam int BIT_LMFC_SET = 3;
   localparam int BIT_PLL_LOCKED = 2;
   // channel_power_down fields
   localparam int BIT_PD_B = 1;
   localparam int BIT_PD_A = 0;
   // extra lane fields
   localparam int BIT_SPARE_SER = 0;
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [7:0] STATUS_W1C_MASK = 8'h18;
   localparam logic [7:0] CHANNEL_POWER_DOWN_MASK = 8'h03;
   // controller registers, Avalon word addresses
   localparam logic [3:0] CA_CMD = 4'h0;
   localparam logic [3:0] CA_WDATA = 4'h1;
   localparam logic [3:0] CA_RDATA = 4'h2;
   localparam logic [3:0] CA_IRQ_STATUS = 4'h3;
   localparam logic [3:0] CA_IRQ_MASK = 4'h4;
   localparam logic [3:0] CA_ENC = 4'h5;
   // cmd word fields
   localparam int CMD_GO = 31;
   localparam int CMD_WR = 30;
   // irq bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_REFUSED = 1;
   localparam int IRQ_REALIGN = 2;
   localparam int IRQ_LMFC = 3;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// [include/lane_ctl_if.sv]
// register port joining the converter link block and its controller
`timescale 1ns/1ps
interface lane_ctl_if;
   logic req;
   logic wr;
   logic [9:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic ack;
   logic link_encoder_enable;
   modport dev (input req, input wr, input addr, input wdata,
      input link_encoder_enable, output rdata, output ack);
   modport ctl (output req, output wr, output addr, output wdata,
      output link_encoder_enable, input rdata, input ack);
endinterface

// [verilog/sticky_flag.sv]
// sticky flag, set by hardware, cleared by writing one
`timescale 1ns/1ps
module sticky_flag
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // set and clear
   input wire logic set_i,
   input wire logic clear_i,
   output logic flag_o
);
   typedef struct packed {logic flag;} st_t;
   st_t s_r;
   st_t s_nxt;
   always_comb
   begin
      s_nxt = s_r;
      if (clear_i)
         s_nxt.flag = 1'b0;
      // a set arriving with the clear is kept
      if (set_i)
         s_nxt.flag = 1'b1;
   end
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
   assign flag_o = s_r.flag;
endmodule

// [verilog/link_controller.sv]
// controller end: Avalon-MM slave driving the link register port
`timescale 1ns/1ps
module link_controller
   import lane_ctl_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq_o,
   // device port
   lane_ctl_if.ctl dev
);
   typedef enum {IDLE, ISSUE, WAIT} ph_t;
   typedef struct packed {
      ph_t ph;
      logic wr;
      logic [9:0] addr;
      logic [7:0] wd;
      logic [7:0] rd;
      logic [3:0] irq;
      logic [3:0] mask;
      logic enc;
      logic [31:0] rdata;
      logic done;
   } st_t;
   st_t s_r;
   st_t s_nxt;
   logic guarded;

   // power and extra lane writes refused while encoder enabled
   assign guarded = avs_writedata[CMD_WR] && s_r.enc && (avs_writedata[9:0] ==
      OFS_CHANNEL_POWER_DOWN || avs_writedata[9:0] == OFS_EXTRA_LANE_A
      || avs_writedata[9:0] == OFS_EXTRA_LANE_B);

   always_comb
   begin
      logic [3:0] ev;
      ev = '0;
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      // phase first, so a command accepted below can leave idle
      case (s_r.ph)
         ISSUE: s_nxt.ph = WAIT;
         WAIT:
         begin
            if (dev.ack)
            begin
               s_nxt.rd = dev.rdata;
               s_nxt.ph = IDLE;
               ev[IRQ_DONE] = 1'b1;
               // watch flags seen on status reads
               if (!s_r.wr && s_r.addr == OFS_LINK_STATUS)
               begin
                  ev[IRQ_REALIGN] = dev.rdata[BIT_REALIGNED];
                  ev[IRQ_LMFC] = dev.rdata[BIT_LMFC_SET];
               end
            end
         end
         default: s_nxt.ph = s_r.ph;
      endcase
      if (avs_read && !s_r.done)
      begin
         s_nxt.done = 1'b1;
         case (avs_address)
            CA_CMD: s_nxt.rdata = {s_r.ph != IDLE, 31'h0};
            CA_WDATA: s_nxt.rdata = {24'h0, s_r.wd};
            CA_RDATA: s_nxt.rdata = {24'h0, s_r.rd};
            CA_IRQ_STATUS: s_nxt.rdata = {28'h0, s_r.irq};
            CA_IRQ_MASK: s_nxt.rdata = {28'h0, s_r.mask};
            CA_ENC: s_nxt.rdata = {31'h0, s_r.enc};
            default: s_nxt.rdata = '0;
         endcase
      end
      if (avs_write && !s_r.done)
         s_nxt.done = 1'b1;
      // the write lands at the edge that sees waitrequest low
      if (avs_write && s_r.done)
      begin
         case (avs_address)
            CA_WDATA: s_nxt.wd = avs_writedata[7:0];
            CA_IRQ_STATUS: s_nxt.irq = s_r.irq & ~avs_writedata[3:0];
            CA_IRQ_MASK: s_nxt.mask = avs_writedata[3:0];
            CA_ENC: s_nxt.enc = avs_writedata[0];
            CA_CMD:
            begin
               if (avs_writedata[CMD_GO] && s_r.ph == IDLE)
               begin
                  s_nxt.wr = avs_writedata[CMD_WR];
                  s_nxt.addr = avs_writedata[9:0];
                  if (guarded)
                     ev[IRQ_REFUSED] = 1'b1;
                  else
                     s_nxt.ph = ISSUE;
               end
            end
            default: s_nxt.wd = s_r.wd;
         endcase
      end
      // set wins over a same-cycle clear
      s_nxt.irq = s_nxt.irq | ev;
   end

   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s_r <= '0;
         s_r.ph <= IDLE;
      end
      else
         s_r <= s_nxt;
   end

   assign avs_readdata = s_r.rdata;
   assign avs_waitrequest = (avs_read || avs_write) && !s_r.done;
   assign irq_o = |(s_r.irq & s_r.mask);
   assign dev.req = s_r.ph != IDLE;
   assign dev.wr = s_r.wr;
   assign dev.addr = s_r.addr;
   assign dev.wdata = s_r.wd;
   assign dev.link_encoder_enable = s_r.enc;
endmodule

// [bench/lane_ctl_monitor.sv]
// protocol and ordering checks on the device register port
`timescale 1ns/1ps
module lane_ctl_monitor
   import lane_ctl_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // register port
   input wire logic req,
   input wire logic wr,
   input wire logic [9:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic ack,
   input wire logic link_encoder_enable
);
   default clocking mon_clk @(posedge clock_i);
   endclocking
   default disable iff (!reset_n_i);
   sequence s_take;
      req && !ack;
   endsequence
   sequence s_answer;
      ack ##1 (!ack && !req);
   endsequence
   logic mapped;
   assign mapped = addr >= OFS_LINK_STATUS && addr <= OFS_EXTRA_LANE_B;
   chk_ack_follows: assert property (s_take |=> s_answer)
      else $error("ack or release missing after request");
   chk_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
      else $error("ack without a pending request");
   chk_req_steady: assert property (s_take |=> $stable(addr) && $stable(wr)
      && $stable(wdata))
      else $error("request changed before ack");
   chk_pd_enc_off: assert property (req && wr
      && addr == OFS_CHANNEL_POWER_DOWN |-> !link_encoder_enable)
      else $error("power-down written with encoder on");
   chk_extra_enc_off: assert property (req && wr
      && (addr == OFS_EXTRA_LANE_A || addr == OFS_EXTRA_LANE_B)
      |-> !link_encoder_enable)
      else $error("extra lanes written with encoder on");
   chk_rdata_steady: assert property ($changed(rdata) |-> ack)
      else $error("read data moved without ack");
   chk_unmapped_zero: assert property (ack && !wr && !mapped
      |-> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_status_reserved: assert property (ack && !wr
      && addr == OFS_LINK_STATUS |-> rdata[7] == 1'h0 && rdata[1:0] == 2'h0)
      else $error("reserved status bits not zero");
endmodule

// [bench/serial_link_status_lane_power_bench.sv]
// bench joining both ends, driven over the avalon port
`timescale 1ns/1ps
module serial_link_status_lane_power_bench;
   import lane_ctl_pkg::*;
   logic clock_i = 1'h0;
   logic reset_n_i = 1'h0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq_o;
   logic link_up_i = 1'h0;
   logic sync_n_i = 1'h0;
   logic sysref_realign_i = 1'h0;
   logic sysref_event_i = 1'h0;
   logic pll_locked_i = 1'h0;
   logic [3:0] link_mode_select_i = 4'h0;
   logic [3:0] test_pattern_select_i = 4'h0;
   logic ch_a, ch_b, sub_on, a_on, b_valid;
   logic [7:0] clk_a, clk_b, ser_a, ser_b, q;
   logic [3:0] mode_o, pat_o;
   logic [31:0] r;
   int bad_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] xv [4] = '{8'h0E, 8'h0F, 8'h17, 8'hFF};
   logic [7:0] ec [4] = '{8'h0F, 8'h0F, 8'h07, 8'hFF};
   logic [7:0] es [4] = '{8'h01, 8'h0F, 8'h07, 8'hFF};
   logic [7:0] pv [4] = '{8'h02, 8'h01, 8'h03, 8'h00};
   logic [4:0] ep [4] = '{5'h16, 5'h0D, 5'h00, 5'h1F};
   logic [7:0] eca [4] = '{8'hFF, 8'h00, 8'h00, 8'hFF};
   logic [7:0] ecb [4] = '{8'h00, 8'hFF, 8'h00, 8'hFF};
   lane_ctl_if link_bus();
   link_status_power i_link_status_power (.clock_i(clock_i),
      .reset_n_i(reset_n_i), .bus(link_bus), .link_up_i(link_up_i),
      .sync_n_i(sync_n_i), .sysref_realign_i(sysref_realign_i),
      .sysref_event_i(sysref_event_i), .pll_locked_i(pll_locked_i),
      .link_mode_select_i(link_mode_select_i),
      .test_pattern_select_i(test_pattern_select_i),
      .channel_a_on_o(ch_a), .channel_b_on_o(ch_b),
      .link_subsystem_on_o(sub_on), .link_a_on_o(a_on),
      .b_samples_valid_o(b_valid), .lane_clk_en_a_o(clk_a),
      .lane_clk_en_b_o(clk_b), .ser_en_a_o(ser_a), .ser_en_b_o(ser_b),
      .lane_mode_o(mode_o), .lane_pattern_o(pat_o));
   link_controller i_link_controller (.clock_i(clock_i),
      .reset_n_i(reset_n_i), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq_o(irq_o), .dev(link_bus));
   lane_ctl_monitor i_lane_ctl_monitor (.clock_i(clock_i),
      .reset_n_i(reset_n_i), .req(link_bus.req), .wr(link_bus.wr),
      .addr(link_bus.addr), .wdata(link_bus.wdata),
      .rdata(link_bus.rdata), .ack(link_bus.ack),
      .link_encoder_enable(link_bus.link_encoder_enable));
   always #5 clock_i = ~clock_i;
   task automatic close_out();
      if (bad_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask
   // one avalon transfer; an extra edge keeps strobes from re-rising at once
   task automatic av_xfer(input logic rd, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] o);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= d;
      do @(posedge clock_i); while (avs_waitrequest !== 1'h0);
      o = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      @(posedge clock_i);
   endtask
   task automatic dev_op(input logic w, input logic [9:0] a,
      input logic [7:0] d, output logic [7:0] o);
      logic [31:0] t;
      av_xfer(1'h0, CA_WDATA, {24'h0, d}, t);
      av_xfer(1'h0, CA_CMD, {1'h1, w, 20'h0, a}, t);
      t = 32'h8000_0000;
      while (t[CMD_GO] === 1'h1) av_xfer(1'h1, CA_CMD, 32'h0, t);
      av_xfer(1'h1, CA_RDATA, 32'h0, t);
      o = t[7:0];
   endtask
   task automatic pulse_ev(input logic re);
      if (re)
         sysref_realign_i <= 1'h1;
      else
         sysref_event_i <= 1'h1;
      @(posedge clock_i);
      sysref_realign_i <= 1'h0;
      sysref_event_i <= 1'h0;
      @(posedge clock_i);
   endtask
   // ceiling far above the several hundred cycles the sequence needs
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         bad_count++;
         close_out();
      end
   end
   initial
   begin
      repeat (12) @(posedge clock_i);
      reset_n_i <= 1'h1;
      repeat (2) @(posedge clock_i);
      cmp_bit(ch_a & ch_b, 1'h1);
      cmp8(clk_a, 8'h01);
      for (int i = 1; i < 4; i++)
      begin
         dev_op(1'h0, 10'(OFS_LINK_STATUS + i), 8'h00, q);
         cmp8(q, RST_REG8);
      end
      link_up_i <= 1'h1;
      pll_locked_i <= 1'h1;
      dev_op(1'h0, OFS_LINK_STATUS, 8'h00, q);
      cmp8(q, 8'h44);
      sync_n_i <= 1'h1;
      link_up_i <= 1'h0;
      pll_locked_i <= 1'h0;
      pulse_ev(1'h1);
      dev_op(1'h1, OFS_LINK_STATUS, 8'hE7, q);
      dev_op(1'h0, OFS_LINK_STATUS, 8'h00, q);
      cmp8(q, 8'h30);
      dev_op(1'h1, OFS_LINK_STATUS, 8'h10, q);
      dev_op(1'h0, OFS_LINK_STATUS, 8'h00, q);
      cmp8(q, 8'h20);
      // done and realign bits are pending here, so the mask decides
      av_xfer(1'h0, CA_IRQ_MASK, 32'h0, r);
      cmp_bit(irq_o, 1'h0);
      av_xfer(1'h0, CA_IRQ_MASK, 32'hF, r);
      cmp_bit(irq_o, 1'h1);
      av_xfer(1'h0, CA_IRQ_STATUS, 32'hF, r);
      cmp_bit(irq_o, 1'h0);
      av_xfer(1'h0, CA_ENC, 32'h1, r);
      pulse_ev(1'h0);
      dev_op(1'h0, OFS_LINK_STATUS, 8'h00, q);
      cmp_bit(q[BIT_LMFC_SET], 1'h1);
      dev_op(1'h1, OFS_LINK_STATUS, 8'h08, q);
      pulse_ev(1'h0);
      dev_op(1'h0, OFS_LINK_STATUS, 8'h00, q);
      cmp_bit(q[BIT_LMFC_SET], 1'h0);
      dev_op(1'h1, OFS_EXTRA_LANE_A, 8'h0F, q);
      av_xfer(1'h1, CA_IRQ_STATUS, 32'h0, r);
      cmp_bit(r[IRQ_REFUSED], 1'h1);
      av_xfer(1'h0, CA_ENC, 32'h0, r);
      dev_op(1'h0, OFS_EXTRA_LANE_A, 8'h00, q);
      cmp8(q, RST_REG8);
      for (int i = 0; i < 4; i++)
      begin
         dev_op(1'h1, OFS_EXTRA_LANE_A, xv[i], q);
         dev_op(1'h1, OFS_EXTRA_LANE_B, xv[i], q);
         cmp8(clk_a, ec[i]);
         cmp8(ser_a, es[i]);
         cmp8(clk_b, ec[i]);
         cmp8(ser_b, es[i]);
      end
      for (int i = 0; i < 4; i++)
      begin
         dev_op(1'h1, OFS_CHANNEL_POWER_DOWN, pv[i], q);
         cmp8({3'h0, ch_a, ch_b, sub_on, a_on, b_valid},
            {3'h0, ep[i]});
         cmp8(clk_a, eca[i]);
         cmp8(clk_b, ecb[i]);
      end
      link_mode_select_i <= 4'hA;
      test_pattern_select_i <= 4'h5;
      @(posedge clock_i);
      cmp8({mode_o, pat_o}, 8'hA5);
      dev_op(1'h0, 10'h3FF, 8'h00, q);
      cmp8(q, 8'h00);
      av_xfer(1'h1, 4'hF, 32'h0, r);
      cmp8(r[7:0], 8'h00);
      close_out();
   end
endmodule
